// [rtl/io_expander_pkg.sv]
// Shared constants, request carrier and state records of the two-wire I/O expander slave.
// Assumes one core clock for the port logic and one sampling clock for the serial bus.
package io_expander_pkg;

	// ----------------------------------------------------------------------
	// Addressing and register layout
	// ----------------------------------------------------------------------
	localparam logic [3:0] ADDR_FIXED = 4'h4;
	localparam logic [7:0] CMD_ERRATA = 8'h00;
	localparam logic [1:0] KIND_INPUT = 2'h0;
	localparam logic [1:0] KIND_OUTPUT = 2'h1;
	localparam logic [1:0] KIND_POLARITY = 2'h2;
	localparam logic [1:0] KIND_CONFIG = 2'h3;
	localparam logic [15:0] OUT_RESET = 16'hffff;
	localparam logic [15:0] POL_RESET = 16'h0000;
	localparam logic [15:0] CFG_RESET = 16'hffff;

	// ----------------------------------------------------------------------
	// Timing counts
	// ----------------------------------------------------------------------
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [1:0] PRIME_DONE = 2'h3;

	// ----------------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_PTR, OP_WRITE, OP_FETCH, OP_CLEAR, OP_CLEAR_FETCH, OP_FOREIGN
	} op_type;

	typedef struct packed {
		op_type op;
		logic [7:0] data;
	} request_type;

	typedef enum logic [3:0] {
		LINK_IDLE, LINK_ADDR, LINK_ADDR_ACK, LINK_WRITE_BYTE, LINK_WRITE_ACK,
		LINK_READ_BYTE, LINK_READ_ACK, LINK_FOREIGN, LINK_SKIP
	} link_state_type;

	typedef struct packed {
		logic [15:0] pin_s1;
		logic [15:0] pin_s2;
		logic [15:0] out_latch;
		logic [15:0] pol;
		logic [15:0] cfg;
		logic [15:0] in_reg;
		logic [2:0] ptr;
		logic cmd_zero;
		logic last_port;
		logic last_input;
		logic [7:0] last_raw;
		logic [1:0] prime;
		logic alert;
		logic req_s1;
		logic req_s2;
		logic req_seen;
		logic ack_tgl;
		logic [7:0] rdata;
	} core_state_type;

	typedef struct packed {
		link_state_type state;
		logic [3:0] cnt;
		logic [7:0] shift;
		logic [7:0] tx;
		logic rw;
		logic nack;
		logic have_cmd;
		logic sda_drive;
		logic scl_s1;
		logic scl_s2;
		logic scl_d;
		logic sda_s1;
		logic sda_s2;
		logic sda_d;
		logic [2:0] asel_s1;
		logic [2:0] asel_s2;
		request_type req;
		logic req_tgl;
		logic ack_s1;
		logic ack_s2;
		logic ack_seen;
	} link_state_type_rec_type;

endpackage

// [rtl/io_expander_slave.sv]
// Two-wire serial slave with a sixteen-pin, two-port I/O expander and a change alert.
// Assumes an external master on the bus and pull-ups on the data and alert wires.
//
// Operation
// - Reset loads defaults and idles the bus engine.
// - All sixteen pins come up as inputs.
// - Input pins leave both drivers off.
// - Output pins follow the output latch bits.
// - Input pin differing from input register raises alert.
// - Alert drops on level return or port read.
// - Read clear happens at acknowledge after clock rise.
// - Changes near acknowledge are kept; the clear stores the levels read.
// - Outputs never alert; foreign writes change nothing.
// - Output-to-input switch may raise an alert.
// - Each port clears only its own alert.
// - Alert is active-low open-drain, pull-down only.
// - Pointer zero plus foreign read acknowledge clears port 0 alert.
// - Address shifted in MSB first; general call ignored.
// - Address is 0100 plus three select pins.
// - Matching address acknowledged low through clock high.
// - Data changes only while clock low.
// - Every byte followed by one acknowledge bit.
// - Master not-acknowledge makes device release data line.
// - First written byte sets the register pointer.
// - Direction bit one reads, zero writes.
// - Configuration one means input, zero means output.
// - Polarity bit set inverts reported input value.
`timescale 1ns/10ps

module io_expander_slave
	import io_expander_pkg::*;
(
	// Core clock and control
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// Serial bus, sampled on its own clock
	input wire logic bus_sample_clk_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// Address select straps
	input wire logic addr_select_bit0_i,
	input wire logic addr_select_bit1_i,
	input wire logic addr_select_bit2_i,
	// Port pins
	input wire logic [7:0] port_low_pins_i,
	output logic [7:0] port_low_pins_o,
	output logic [7:0] port_low_pins_oe_o,
	input wire logic [7:0] port_high_pins_i,
	output logic [7:0] port_high_pins_o,
	output logic [7:0] port_high_pins_oe_o,
	// Change alert, open drain
	output logic alert_o,
	output logic alert_oe_o
);

	// ----------------------------------------------------------------------
	// Reset constants
	// ----------------------------------------------------------------------
	localparam core_state_type CORE_RESET = '{
		out_latch: OUT_RESET, pol: POL_RESET, cfg: CFG_RESET, cmd_zero: 1'b1,
		default: '0};
	localparam link_state_type_rec_type LINK_RESET = '{
		state: LINK_IDLE, req: '{op: OP_PTR, data: 8'h00},
		scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
		default: '0};

	core_state_type st;
	core_state_type next_st;
	link_state_type_rec_type lk;
	link_state_type_rec_type next_lk;

	// ----------------------------------------------------------------------
	// Reset and enable carried into the bus sampling domain
	// ----------------------------------------------------------------------
	logic lrst_s1;
	logic lrst_s2;
	logic lce_s1;
	logic lce_s2;

	always_ff @(posedge bus_sample_clk_i)
	begin
		lrst_s1 <= reset_i;
		lrst_s2 <= lrst_s1;
		lce_s1 <= ce_i;
		lce_s2 <= lce_s1;
	end

	// ----------------------------------------------------------------------
	// Core domain: registers, pins and alert
	// ----------------------------------------------------------------------
	logic [15:0] mismatch;
	logic new_req;
	logic do_clear;
	logic do_fetch;
	logic [7:0] raw_byte;
	logic [7:0] wr_byte;

	always_comb
	begin
		next_st = st;
		next_st.pin_s1 = {port_high_pins_i, port_low_pins_i};
		next_st.pin_s2 = st.pin_s1;
		next_st.req_s1 = lk.req_tgl;
		next_st.req_s2 = st.req_s1;
		// The input register starts as a copy of the pins so power-up raises no alert.
		if (st.prime != PRIME_DONE)
		begin
			next_st.prime = st.prime + 2'h1;
			next_st.in_reg = st.pin_s2;
		end
		// Only input-mode pins compare; outputs cannot alert.
		mismatch = (st.prime == PRIME_DONE) ? ((st.pin_s2 ^ st.in_reg) & st.cfg) : 16'h0000;
		// Alert falls by itself once the pins return to the stored levels.
		next_st.alert = |mismatch;
		new_req = st.req_s2 != st.req_seen;
		do_clear = new_req && (lk.req.op == OP_CLEAR || lk.req.op == OP_CLEAR_FETCH);
		do_fetch = new_req && (lk.req.op == OP_FETCH || lk.req.op == OP_CLEAR_FETCH);
		raw_byte = st.pin_s2[{st.ptr[0], 3'h0} +: 8];
		wr_byte = lk.req.data;
		if (new_req)
		begin
			next_st.req_seen = st.req_s2;
			next_st.ack_tgl = ~st.ack_tgl;
			case (lk.req.op)
				OP_PTR:
				begin
					// Only the low three bits select a register.
					next_st.ptr = wr_byte[2:0];
					next_st.cmd_zero = wr_byte == CMD_ERRATA;
				end
				OP_WRITE:
				begin
					case (st.ptr[2:1])
						KIND_OUTPUT: next_st.out_latch[{st.ptr[0], 3'h0} +: 8] = wr_byte;
						KIND_POLARITY: next_st.pol[{st.ptr[0], 3'h0} +: 8] = wr_byte;
						KIND_CONFIG: next_st.cfg[{st.ptr[0], 3'h0} +: 8] = wr_byte;
						default: next_st.ptr = st.ptr;
					endcase
					next_st.ptr[0] = ~st.ptr[0];
				end
				OP_FOREIGN:
				begin
					// Deliberate copy of the known false clear: pointer zero clears port 0.
					if (st.cmd_zero)
						next_st.in_reg[7:0] = st.pin_s2[7:0];
				end
				default: next_st.ptr = st.ptr;
			endcase
		end
		// Clear touches only the byte of the port that was read.
		if (do_clear && st.last_input)
			next_st.in_reg[{st.last_port, 3'h0} +: 8] = st.last_raw;
		if (do_fetch)
		begin
			case (st.ptr[2:1])
				KIND_INPUT: next_st.rdata = raw_byte ^ st.pol[{st.ptr[0], 3'h0} +: 8];
				KIND_OUTPUT: next_st.rdata = st.out_latch[{st.ptr[0], 3'h0} +: 8];
				KIND_POLARITY: next_st.rdata = st.pol[{st.ptr[0], 3'h0} +: 8];
				default: next_st.rdata = st.cfg[{st.ptr[0], 3'h0} +: 8];
			endcase
			// The clear stores the levels that were actually read, so a change between
			// the read and its acknowledge stays visible as an alert.
			next_st.last_raw = raw_byte;
			next_st.last_port = st.ptr[0];
			next_st.last_input = st.ptr[2:1] == KIND_INPUT;
			next_st.ptr[0] = ~st.ptr[0];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			st <= CORE_RESET;
		else if (ce_i)
			st <= next_st;
	end

	// Inputs leave both drivers off; outputs drive the latch.
	assign port_low_pins_o = st.out_latch[7:0];
	assign port_high_pins_o = st.out_latch[15:8];
	assign port_low_pins_oe_o = ~st.cfg[7:0];
	assign port_high_pins_oe_o = ~st.cfg[15:8];
	// The alert only ever pulls low.
	assign alert_o = 1'b0;
	assign alert_oe_o = st.alert;

	// ----------------------------------------------------------------------
	// Link domain: bit engine on the sampling clock
	// ----------------------------------------------------------------------
	logic rise;
	logic fall;
	logic start;
	logic stop;

	always_comb
	begin
		next_lk = lk;
		next_lk.scl_s1 = scl_i;
		next_lk.scl_s2 = lk.scl_s1;
		next_lk.scl_d = lk.scl_s2;
		next_lk.sda_s1 = sda_i;
		next_lk.sda_s2 = lk.sda_s1;
		next_lk.sda_d = lk.sda_s2;
		next_lk.asel_s1 = {addr_select_bit2_i, addr_select_bit1_i, addr_select_bit0_i};
		next_lk.asel_s2 = lk.asel_s1;
		next_lk.ack_s1 = st.ack_tgl;
		next_lk.ack_s2 = lk.ack_s1;
		rise = lk.scl_s2 && !lk.scl_d;
		fall = !lk.scl_s2 && lk.scl_d;
		// Data moving while the clock is high is a frame marker.
		start = lk.scl_s2 && lk.scl_d && lk.sda_d && !lk.sda_s2;
		stop = lk.scl_s2 && lk.scl_d && !lk.sda_d && lk.sda_s2;
		// The core holds the read byte steady until the next request.
		if (lk.ack_s2 != lk.ack_seen)
		begin
			next_lk.ack_seen = lk.ack_s2;
			next_lk.tx = st.rdata;
		end
		case (lk.state)
			LINK_ADDR, LINK_WRITE_BYTE:
			begin
				if (rise)
				begin
					next_lk.shift = {lk.shift[6:0], lk.sda_s2};
					next_lk.cnt = lk.cnt + 4'h1;
				end
				if (fall && lk.cnt == BITS_PER_BYTE)
				begin
					next_lk.cnt = 4'h0;
					if (lk.state == LINK_WRITE_BYTE)
					begin
						next_lk.req = '{op: lk.have_cmd ? OP_WRITE : OP_PTR, data: lk.shift};
						next_lk.req_tgl = ~lk.req_tgl;
						next_lk.have_cmd = 1'b1;
						next_lk.sda_drive = 1'b1;
						next_lk.state = LINK_WRITE_ACK;
					end
					// Fixed upper bits keep the general call unanswered.
					else if (lk.shift[7:1] == {ADDR_FIXED, lk.asel_s2})
					begin
						next_lk.rw = lk.shift[0];
						next_lk.sda_drive = 1'b1;
						next_lk.state = LINK_ADDR_ACK;
					end
					else
						next_lk.state = lk.shift[0] ? LINK_FOREIGN : LINK_SKIP;
				end
			end
			LINK_ADDR_ACK:
			begin
				if (rise && lk.rw)
				begin
					next_lk.req = '{op: OP_FETCH, data: 8'h00};
					next_lk.req_tgl = ~lk.req_tgl;
				end
				if (fall)
				begin
					next_lk.sda_drive = lk.rw && !lk.tx[LAST_BIT];
					next_lk.state = lk.rw ? LINK_READ_BYTE : LINK_WRITE_BYTE;
				end
			end
			LINK_WRITE_ACK:
			begin
				if (fall)
				begin
					next_lk.sda_drive = 1'b0;
					next_lk.state = LINK_WRITE_BYTE;
				end
			end
			LINK_READ_BYTE:
			begin
				if (rise)
					next_lk.cnt = lk.cnt + 4'h1;
				if (fall)
				begin
					// Released for the master's acknowledge once eight bits are out.
					if (lk.cnt == BITS_PER_BYTE)
					begin
						next_lk.sda_drive = 1'b0;
						next_lk.state = LINK_READ_ACK;
					end
					else
						next_lk.sda_drive = !lk.tx[LAST_BIT - lk.cnt[2:0]];
				end
			end
			LINK_READ_ACK:
			begin
				if (rise)
				begin
					next_lk.nack = lk.sda_s2;
					next_lk.req = '{op: lk.sda_s2 ? OP_CLEAR : OP_CLEAR_FETCH, data: 8'h00};
					next_lk.req_tgl = ~lk.req_tgl;
				end
				if (fall)
				begin
					next_lk.cnt = 4'h0;
					// After a not-acknowledge the line stays released until the next start or stop.
					next_lk.sda_drive = !lk.nack && !lk.tx[LAST_BIT];
					next_lk.state = lk.nack ? LINK_SKIP : LINK_READ_BYTE;
				end
			end
			LINK_FOREIGN:
			begin
				// Another slave answering a read address is watched at its acknowledge.
				if (rise)
				begin
					if (!lk.sda_s2)
					begin
						next_lk.req = '{op: OP_FOREIGN, data: 8'h00};
						next_lk.req_tgl = ~lk.req_tgl;
					end
					next_lk.state = LINK_SKIP;
				end
			end
			default: next_lk.state = lk.state;
		endcase
		if (start)
		begin
			next_lk.state = LINK_ADDR;
			next_lk.cnt = 4'h0;
			next_lk.have_cmd = 1'b0;
			next_lk.sda_drive = 1'b0;
		end
		else if (stop)
		begin
			next_lk.state = LINK_IDLE;
			next_lk.sda_drive = 1'b0;
		end
	end

	always_ff @(posedge bus_sample_clk_i)
	begin
		if (lrst_s2)
			lk <= LINK_RESET;
		else if (lce_s2)
			lk <= next_lk;
	end

	assign sda_o = 1'b0;
	assign sda_oe_o = lk.sda_drive;

	// ----------------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------------
	sequence seq_clear_port1;
		do_clear && st.last_input && st.last_port && ce_i;
	endsequence

	sequence seq_foreign_zero;
		new_req && lk.req.op == OP_FOREIGN && st.cmd_zero && ce_i;
	endsequence

	chk_reset_inputs: assert property (@(posedge clk_i)
		$past(reset_i) && !reset_i |-> port_low_pins_oe_o == 8'h00 && port_high_pins_oe_o == 8'h00)
		else $error("pins not inputs after reset");
	chk_input_hiz: assert property (@(posedge clk_i) disable iff (reset_i)
		(st.cfg & {port_high_pins_oe_o, port_low_pins_oe_o}) == 16'h0000)
		else $error("input pin is driven");
	chk_output_value: assert property (@(posedge clk_i) disable iff (reset_i)
		(({port_high_pins_o, port_low_pins_o} ^ st.out_latch) & ~st.cfg) == 16'h0000)
		else $error("output pin differs from latch");
	chk_alert_raise: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && mismatch != 16'h0000 |=> alert_oe_o)
		else $error("input change did not raise alert");
	chk_alert_release: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && mismatch == 16'h0000 |=> !alert_oe_o)
		else $error("alert held without a difference");
	chk_output_quiet: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && st.prime == PRIME_DONE && ((st.pin_s2 ^ st.in_reg) & st.cfg) == 16'h0000
		&& ((st.pin_s2 ^ st.in_reg) & ~st.cfg) != 16'h0000 |=> !alert_oe_o)
		else $error("output pins raised alert");
	chk_port_split: assert property (@(posedge clk_i) disable iff (reset_i)
		(seq_clear_port1 and (st.prime == PRIME_DONE && !(new_req && lk.req.op == OP_FOREIGN)))
		|=> $stable(st.in_reg[7:0]))
		else $error("port 1 read cleared port 0");
	chk_errata_clear: assert property (@(posedge clk_i) disable iff (reset_i)
		seq_foreign_zero |=> st.in_reg[7:0] == $past(st.pin_s2[7:0]))
		else $error("foreign read did not clear port 0");
	chk_alert_drain: assert property (@(posedge clk_i) disable iff (reset_i)
		alert_o == 1'b0)
		else $error("alert drives high");
	chk_addr_ack: assert property (@(posedge bus_sample_clk_i) disable iff (lrst_s2)
		lk.state == LINK_ADDR_ACK && lk.scl_s2 |-> sda_oe_o)
		else $error("address not acknowledged");
	chk_nack_release: assert property (@(posedge bus_sample_clk_i) disable iff (lrst_s2)
		lk.state == LINK_SKIP |-> !sda_oe_o)
		else $error("data line held after not-acknowledge");
	chk_start_addr: assert property (@(posedge bus_sample_clk_i) disable iff (lrst_s2)
		start && lce_s2 |=> lk.state == LINK_ADDR && lk.cnt == 4'h0 && !sda_oe_o)
		else $error("start did not open address phase");

endmodule

// [tb/i2c_master_model.sv]
// Bus master model for the two-wire serial port: it drives the clock and pulls data low.
// Assumes a pull-up on the data wire and a free-running sampling clock that paces each bit.
`timescale 1ns/10ps

module i2c_master_model #(
	parameter int QUARTER = 20
) (
	// Pacing clock
	input wire logic lclk_i,
	// Bus wires
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_pull_o
);
	// ----------------------------------------------------------------------
	// Bit and frame tasks
	// ----------------------------------------------------------------------
	// A half period of two quarters keeps the slave's sampling margin met.
	initial
	begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge lclk_i);
	endtask

	task automatic start_cond();
		sda_pull_o <= 1'b0;
		hold(QUARTER);
		scl_o <= 1'b1;
		hold(QUARTER);
		sda_pull_o <= 1'b1;
		hold(QUARTER);
		scl_o <= 1'b0;
		hold(QUARTER);
	endtask

	task automatic stop_cond();
		sda_pull_o <= 1'b1;
		hold(QUARTER);
		scl_o <= 1'b1;
		hold(QUARTER);
		sda_pull_o <= 1'b0;
		hold(2 * QUARTER);
	endtask

	task automatic bit_io(input logic b, output logic r);
		sda_pull_o <= ~b;
		hold(QUARTER);
		scl_o <= 1'b1;
		hold(QUARTER);
		r = sda_i;
		hold(QUARTER);
		scl_o <= 1'b0;
		hold(QUARTER);
	endtask

	// A set fake_ack stands in for another slave pulling the acknowledge low.
	task automatic write_byte(input logic [7:0] d, input logic fake_ack, output logic acked);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(~fake_ack, r);
		acked = ~r;
	endtask

	task automatic read_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(last, r);
	endtask
endmodule

// [tb/tb.sv]
// Self-checking bench of the two-wire I/O expander slave and its change alert.
// Assumes the master model above and pull-ups on the data wire; pins loop back by enable.
`timescale 1ns/10ps

module tb;
	import io_expander_pkg::*;

	localparam logic [6:0] DEV = {ADDR_FIXED, 3'h5};

	logic clk_i = 1'b0;
	logic lclk;
	logic reset_i;
	logic [2:0] strap;
	logic [7:0] ext_low, ext_high, low_o, low_oe, high_o, high_oe, low_pins, high_pins;
	logic sda_o, sda_oe, alert_o, alert_oe, scl, pull, sda_w;
	logic ce;
	int err_total, checked;

	// ----------------------------------------------------------------------
	// Clocks, wires and instances
	// ----------------------------------------------------------------------
	always #2.5 clk_i = ~clk_i;

	initial
	begin
		lclk = 1'b0;
		#1.3;
		forever #7.5 lclk = ~lclk;
	end

	assign sda_w = ~pull & (sda_oe ? sda_o : 1'b1);
	assign low_pins = (low_oe & low_o) | (~low_oe & ext_low);
	assign high_pins = (high_oe & high_o) | (~high_oe & ext_high);

	i2c_master_model master (.lclk_i(lclk), .sda_i(sda_w), .scl_o(scl), .sda_pull_o(pull));

	io_expander_slave dut (
		.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce), .bus_sample_clk_i(lclk),
		.scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
		.addr_select_bit0_i(strap[0]), .addr_select_bit1_i(strap[1]),
		.addr_select_bit2_i(strap[2]), .port_low_pins_i(low_pins), .port_low_pins_o(low_o),
		.port_low_pins_oe_o(low_oe), .port_high_pins_i(high_pins), .port_high_pins_o(high_o),
		.port_high_pins_oe_o(high_oe), .alert_o(alert_o), .alert_oe_o(alert_oe)
	);

	// ----------------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------------
	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	task automatic set_pins(input logic [7:0] low, input logic [7:0] high);
		@(posedge clk_i);
		ext_low <= low;
		ext_high <= high;
		repeat (20) @(posedge clk_i);
	endtask

	task automatic addr_only(input logic [7:0] b, input logic pull_ack, input logic exp);
		logic a;
		master.start_cond();
		master.write_byte(b, pull_ack, a);
		master.stop_cond();
		check("address ack", exp, a);
	endtask

	task automatic wr(input logic [7:0] ptr, input logic [15:0] data, input int n, input logic keep);
		logic a;
		master.start_cond();
		master.write_byte({DEV, 1'b0}, 1'b0, a);
		check("write address ack", 1, a);
		master.write_byte(ptr, 1'b0, a);
		check("pointer ack", 1, a);
		for (int i = 0; i < n; i++)
		begin
			master.write_byte(data[15 - 8 * i -: 8], 1'b0, a);
			check("data ack", 1, a);
		end
		if (!keep)
			master.stop_cond();
	endtask

	task automatic rd(input logic [7:0] ptr, input logic [15:0] exp, input int n, input string name);
		logic a;
		logic [7:0] d;
		wr(ptr, 16'h0000, 0, 1'b1);
		master.start_cond();
		master.write_byte({DEV, 1'b1}, 1'b0, a);
		check("read address ack", 1, a);
		for (int i = 0; i < n; i++)
		begin
			master.read_byte(i == n - 1, d);
			check(name, exp[15 - 8 * i -: 8], d);
		end
		master.stop_cond();
		repeat (20) @(posedge clk_i);
	endtask

	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ----------------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------------
	initial
	begin
		err_total = 0;
		checked = 0;
		reset_i = 1'b1;
		ce = 1'b1;
		strap = 3'h5;
		ext_low = 8'h00;
		ext_high = 8'h00;
		// Ten core cycles also cover three sampling-clock edges of the link side.
		repeat (10) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (100) @(posedge clk_i);
		check("pin enables", 16'h0000, {low_oe, high_oe});
		check("output latch", OUT_RESET, {low_o, high_o});
		check("data drive", 0, sda_oe);
		check("alert", 0, alert_oe);
		addr_only({ADDR_FIXED, 3'h4, 1'b0}, 1'b0, 1'b0);
		addr_only(8'h00, 1'b0, 1'b0);
		addr_only({DEV, 1'b0}, 1'b0, 1'b1);
		wr(8'h02, 16'ha53c, 2, 1'b0);
		wr(8'h04, 16'h0200, 1, 1'b0);
		wr(8'h06, 16'h0ff0, 2, 1'b0);
		repeat (20) @(posedge clk_i);
		check("pin enables", 16'hf00f, {low_oe, high_oe});
		check("output latch", 16'ha53c, {low_o, high_o});
		check("alert", 0, alert_oe);
		rd(8'h06, 16'h0ff0, 2, "config readback");
		rd(8'h03, 16'h3ca5, 2, "output readback");
		set_pins(8'h01, 8'h00);
		check("alert", 1, alert_oe);
		set_pins(8'h00, 8'h00);
		check("alert", 0, alert_oe);
		set_pins(8'h01, 8'h80);
		check("alert", 1, alert_oe);
		rd(8'h01, 16'h8c00, 1, "port high input");
		check("alert", 1, alert_oe);
		rd(8'h00, 16'ha300, 1, "port low input");
		check("alert", 0, alert_oe);
		set_pins(8'h00, 8'h80);
		check("alert", 1, alert_oe);
		addr_only(8'ha0, 1'b1, 1'b1);
		repeat (20) @(posedge clk_i);
		check("alert", 1, alert_oe);
		addr_only(8'ha1, 1'b1, 1'b1);
		repeat (20) @(posedge clk_i);
		check("alert", 0, alert_oe);
		set_pins(8'h00, 8'h80);
		check("alert", 0, alert_oe);
		// A low enable must freeze the pin samplers, so no alert appears until it returns.
		ce <= 1'b0;
		set_pins(8'h02, 8'h80);
		check("frozen alert", 0, alert_oe);
		ce <= 1'b1;
		set_pins(8'h02, 8'h80);
		check("alert", 1, alert_oe);
		wr(8'h06, 16'hff00, 1, 1'b0);
		repeat (20) @(posedge clk_i);
		check("pin enables", 16'h000f, {low_oe, high_oe});
		check("alert", 1, alert_oe);
		check("alert wire", 0, alert_oe ? alert_o : 1'b1);
		print_verdict();
	end

	// The tests take about eighty-eight thousand core cycles.
	initial
	begin
		repeat (95000) @(posedge clk_i);
		err_total++;
		print_verdict();
	end
endmodule
